//--- logic/saf_pkg.sv
// shared constants for the security attribution filter
`default_nettype none
package saf_pkg;
    // ------
    // attribute encodings and sizes
    // ------
    localparam int SAF_REGIONS = 8;
    localparam logic [1:0] SAF_ATTR_S = 2'h0;
    localparam logic [1:0] SAF_ATTR_NS = 2'h1;
    localparam logic [1:0] SAF_ATTR_NSC = 2'h2;

    // ------
    // register byte offsets
    // ------
    localparam logic [7:0] SAF_OFS_CTRL = 8'h00;
    localparam logic [7:0] SAF_OFS_STATUS = 8'h04;
    localparam logic [7:0] SAF_OFS_PERIPH_ATTR = 8'h08;
    localparam logic [7:0] SAF_OFS_FINE_ATTR = 8'h0C;
    localparam logic [7:0] SAF_OFS_DMA_CH_ATTR = 8'h10;
    localparam logic [7:0] SAF_OFS_BMPU_ATTR = 8'h14;
    localparam logic [7:0] SAF_OFS_BMPU_DENY = 8'h18;
    localparam logic [7:0] SAF_OFS_REGION_ATTR = 8'h1C;

    // ------
    // field positions
    // ------
    localparam int SAF_CTRL_PE_NS_ALLOW = 0;
    localparam int SAF_CTRL_FAULT_NMI = 1;
    localparam int SAF_CTRL_DMA_START_NS = 2;
    localparam int SAF_ST_PE_ERR = 0;
    localparam int SAF_ST_DMA_MF_ERR = 1;
    localparam int SAF_ST_DTE_MF_ERR = 2;
    localparam int SAF_ST_SEC_FAULT = 3;
    localparam int SAF_ST_PERIPH_ERR = 4;
    localparam int SAF_ST_ETH_ERR = 5;
    localparam int SAF_ST_CUR_NS = 8;
    localparam int SAF_ST_LC_SSD = 9;
    localparam int SAF_BMPU_DMA = 0;
    localparam int SAF_BMPU_DTE = 1;
    localparam int SAF_BMPU_ETH = 2;

    // ------
    // reset values
    // ------
    localparam logic [2:0] SAF_CTRL_RST = 3'h0;
    localparam logic [31:0] SAF_PERIPH_ATTR_RST = 32'h0000_0000;
    localparam logic [31:0] SAF_FINE_ATTR_RST = 32'h0000_0000;
    localparam logic [3:0] SAF_BMPU_RST = 4'h0;
    localparam logic [31:0] SAF_RBASE_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] SAF_RLIMIT_RST = 32'h0000_0000;
endpackage
`default_nettype wire

//--- logic/saf_filter.sv
// security attribution filter for processor, dma, transfer engine and ethernet masters
// Functional notes
// - secure reaches all; non-secure reaches non-secure only
// - security state ignores thread/handler mode
// - secure at reset; no extension means non-secure
// - eight regions classify flash and sram
// - regions programmable only in secure development state
// - non-secure flash read of secure faults
// - program/erase entry secure-only or both
// - program/erase entry defaults secure-only
// - refused program/erase entry sets error flag
// - block protection for both security kinds
// - non-secure sram access to secure blocked, faults
// - same attribution for cpu, dma, engine
// - dma master filter blocks non-secure channel violations
// - master filter error raises dma error interrupt
// - each dma channel has own attribute
// - dma start permission set by secure only
// - ethernet dma always non-secure
// - bus master protection attributes secure-written
// - one attribute per peripheral, secure written
// - peripheral channels hold separate attributes
// - fine-grained peripherals attribute per register
// - listed external interfaces permanently non-secure
// - non-secure access to secure peripheral errors
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module saf_filter
    import saf_pkg::*;
#(
    parameter bit SEC_EXT = 1'b1,
    parameter int DMA_CHANNELS = 8,
    parameter logic [31:0] CFLASH_BASE = 32'h0000_0000,
    parameter logic [31:0] CFLASH_LIMIT = 32'h000F_FFFF,
    parameter logic [31:0] DFLASH_BASE = 32'h0800_0000,
    parameter logic [31:0] DFLASH_LIMIT = 32'h0800_1FFF,
    parameter logic [31:0] SRAM_BASE = 32'h2000_0000,
    parameter logic [31:0] SRAM_LIMIT = 32'h2003_FFFF,
    parameter logic [14:0] PERIPH_PAGE = 15'h2000,
    parameter logic [31:0] ALWAYS_NS_MASK = 32'hF000_0000,
    parameter logic [4:0] FINE_SLOT = 5'h01
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_NS,
    output logic [31:0] REG_RDATA,
    input wire logic LC_SSD,
    input wire logic PROG_WE,
    input wire logic [$clog2(SAF_REGIONS)-1:0] PROG_IDX,
    input wire logic [31:0] PROG_BASE,
    input wire logic [31:0] PROG_LIMIT,
    input wire logic [1:0] PROG_ATTR,
    input wire logic CPU_STATE_UPD,
    input wire logic CPU_STATE_NS,
    input wire logic CPU_REQ,
    input wire logic [31:0] CPU_ADDR,
    input wire logic CPU_WRITE,
    output logic CPU_GO,
    output logic CPU_ERR,
    input wire logic DMA_REQ,
    input wire logic [$clog2(DMA_CHANNELS)-1:0] DMA_CH,
    input wire logic [31:0] DMA_ADDR,
    input wire logic DMA_WRITE,
    output logic DMA_GO,
    output logic DMA_BUS_NS,
    input wire logic DTE_REQ,
    input wire logic DTE_NS,
    input wire logic [31:0] DTE_ADDR,
    input wire logic DTE_WRITE,
    output logic DTE_GO,
    input wire logic ETH_REQ,
    input wire logic [31:0] ETH_ADDR,
    input wire logic ETH_WRITE,
    output logic ETH_GO,
    input wire logic PE_ENTRY_REQ,
    input wire logic PE_ENTRY_NS,
    output logic PE_ENTRY_GO,
    output logic PE_ERROR_FLAG,
    input wire logic DMA_START_REQ,
    input wire logic DMA_START_NS,
    output logic DMA_START_GO,
    output logic SECURE_FAULT_RESET,
    output logic SECURE_FAULT_NMI,
    output logic PERIPH_ACCESS_ERR,
    output logic DMA_TRANSFER_ERROR_IRQ
);
    // ------
    // state
    // ------
    typedef struct packed {
        logic [2:0] ctrl;
        logic [5:0] stat;
        logic [31:0] psar;
        logic [31:0] fine;
        logic [DMA_CHANNELS-1:0] dmach;
        logic [3:0] bmpu_attr;
        logic [3:0] bmpu_deny;
        logic [SAF_REGIONS-1:0][31:0] rbase;
        logic [SAF_REGIONS-1:0][31:0] rlimit;
        logic [SAF_REGIONS-1:0][1:0] rattr;
        logic cur_ns;
        logic [31:0] rdata;
        logic fault_rst;
        logic fault_nmi;
        logic perr_pulse;
        logic dma_irq;
    } saf_state_type;

    saf_state_type state_reg;
    saf_state_type state_next;

    logic [1:0] cpu_v;
    logic [1:0] dma_v;
    logic [1:0] dte_v;
    logic [1:0] eth_v;
    logic dma_ns;
    logic dte_ns;
    logic pe_ns;
    logic sec_fault;
    logic pe_err;
    logic dma_mf;
    logic dte_mf;
    logic perr;
    logic eth_err;
    logic reg_sec;
    logic [5:0] st_clr;
    logic [5:0] st_set;
    logic [3:0] deny_mask;
    logic [31:0] rd_val;
    logic [2*SAF_REGIONS-1:0] rattr_flat;

    // ------
    // access check, shared by every master
    // ------
    // returns {peripheral violation, memory violation}; pure address
    // compare so the verdict is ready in the request cycle
    function automatic logic [1:0] saf_check(input logic [31:0] a, input logic wr, input logic ns);
        logic [1:0] attr;
        logic hit;
        logic flash;
        logic sram;
        logic per;
        logic psec;
        logic [4:0] slot;
        attr = SAF_ATTR_S;
        hit = 1'b0;
        slot = a[16:12];
        for (int i = 0; i < SAF_REGIONS; i++)
        begin
            if (!hit && a >= state_reg.rbase[i] && a <= state_reg.rlimit[i])
            begin
                hit = 1'b1;
                attr = state_reg.rattr[i];
            end
        end
        flash = (a >= CFLASH_BASE && a <= CFLASH_LIMIT) || (a >= DFLASH_BASE && a <= DFLASH_LIMIT);
        sram = a >= SRAM_BASE && a <= SRAM_LIMIT;
        per = a[31:17] == PERIPH_PAGE;
        // one attribute per slot; channels use their own slots
        psec = !state_reg.psar[slot];
        // fine-grained slot uses one attribute bit per register word
        if (slot == FINE_SLOT)
        begin
            psec = !state_reg.fine[a[6:2]];
        end
        // hard non-secure slots have no secure setting
        if (ALWAYS_NS_MASK[slot])
        begin
            psec = 1'b0;
        end
        // flash read of secure region; callable region stays readable
        // sram secure or callable region refuses any non-secure access
        saf_check[0] = ns
                       && ((flash
                       && (attr == SAF_ATTR_S || (wr && attr == SAF_ATTR_NSC)))
                       || (sram && attr != SAF_ATTR_NS));
        saf_check[1] = ns && per && psec;
        // without the extension nothing is secure
        if (!SEC_EXT)
        begin
            saf_check = 2'b00;
        end
    endfunction

    // ------
    // per-master verdicts
    // ------
    // channel attribute taken from its own bit
    assign dma_ns = state_reg.dmach[DMA_CH] | ~SEC_EXT;
    assign dte_ns = DTE_NS | ~SEC_EXT;
    // a process, not assigns: the check reads the region table and the
    // attribute registers, and a write there must re-evaluate every verdict
    // even while the request address holds still
    always_comb
    begin
        // one check function for cpu, dma and transfer engine
        // only the security state enters, never the execution mode
        cpu_v = saf_check(CPU_ADDR, CPU_WRITE, state_reg.cur_ns);
        dma_v = saf_check(DMA_ADDR, DMA_WRITE, dma_ns);
        dte_v = saf_check(DTE_ADDR, DTE_WRITE, dte_ns);
        // ethernet dma is checked as non-secure always
        eth_v = saf_check(ETH_ADDR, ETH_WRITE, 1'b1);
    end

    // grants are combinational so a blocked access never reaches memory
    assign CPU_GO = CPU_REQ & ~|cpu_v;
    assign CPU_ERR = CPU_REQ & cpu_v[1];
    // violating dma and engine accesses are never granted
    assign DMA_GO = DMA_REQ & ~|dma_v & ~state_reg.bmpu_deny[SAF_BMPU_DMA];
    assign DMA_BUS_NS = dma_ns;
    assign DTE_GO = DTE_REQ & ~|dte_v & ~state_reg.bmpu_deny[SAF_BMPU_DTE];
    assign ETH_GO = ETH_REQ & ~|eth_v & ~state_reg.bmpu_deny[SAF_BMPU_ETH];

    // program/erase entry and dma start permission
    assign pe_ns = PE_ENTRY_NS | ~SEC_EXT;
    // non-secure entry only when allowed by control
    assign PE_ENTRY_GO = PE_ENTRY_REQ & (~pe_ns | state_reg.ctrl[SAF_CTRL_PE_NS_ALLOW] | ~SEC_EXT);
    assign DMA_START_GO = DMA_START_REQ & (~DMA_START_NS | state_reg.ctrl[SAF_CTRL_DMA_START_NS] | ~SEC_EXT);

    // ------
    // events
    // ------
    // refused entry gives a flag, not a fault
    assign pe_err = PE_ENTRY_REQ & ~PE_ENTRY_GO;
    assign sec_fault = CPU_REQ & cpu_v[0];
    // master filter errors of both dma masters
    assign dma_mf = DMA_REQ & dma_v[0];
    assign dte_mf = DTE_REQ & dte_v[0];
    assign eth_err = ETH_REQ & |eth_v;
    assign perr = (CPU_REQ & cpu_v[1]) | (DMA_REQ & dma_v[1]) | (DTE_REQ & dte_v[1]);
    assign st_set = {eth_err, perr, sec_fault, dte_mf, dma_mf, pe_err};
    assign st_clr = (REG_WR && REG_ADDR == SAF_OFS_STATUS) ? REG_WDATA[5:0] : 6'h00;
    // without the extension every writer counts as secure-capable
    assign reg_sec = ~REG_NS | ~SEC_EXT;
    // non-secure may touch only deny bits whose attribute allows it
    assign deny_mask = reg_sec ? 4'hF : state_reg.bmpu_attr;

    // ------
    // read mux
    // ------
    // secure-only registers read as zero to non-secure software
    always_comb
    begin
        rattr_flat = state_reg.rattr;
        rd_val = 32'h0000_0000;
        unique case (REG_ADDR)
            SAF_OFS_CTRL: rd_val = reg_sec ? 32'(state_reg.ctrl) : 32'h0000_0000;
            SAF_OFS_STATUS:
            begin
                rd_val[5:0] = state_reg.stat;
                rd_val[SAF_ST_CUR_NS] = state_reg.cur_ns;
                rd_val[SAF_ST_LC_SSD] = LC_SSD;
            end
            SAF_OFS_PERIPH_ATTR: rd_val = reg_sec ? (state_reg.psar | ALWAYS_NS_MASK) : 32'h0000_0000;
            SAF_OFS_FINE_ATTR: rd_val = reg_sec ? state_reg.fine : 32'h0000_0000;
            SAF_OFS_DMA_CH_ATTR: rd_val = reg_sec ? 32'(state_reg.dmach) : 32'h0000_0000;
            SAF_OFS_BMPU_ATTR: rd_val = reg_sec ? 32'(state_reg.bmpu_attr) : 32'h0000_0000;
            SAF_OFS_BMPU_DENY: rd_val = 32'(state_reg.bmpu_deny);
            SAF_OFS_REGION_ATTR: rd_val = 32'(rattr_flat);
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ------
    // next state
    // ------
    always_comb
    begin
        state_next = state_reg;
        state_next.fault_rst = 1'b0;
        state_next.fault_nmi = 1'b0;
        // fault goes out as reset or nmi as control selects
        if (sec_fault)
        begin
            if (state_reg.ctrl[SAF_CTRL_FAULT_NMI])
            begin
                state_next.fault_nmi = 1'b1;
            end
            else
            begin
                state_next.fault_rst = 1'b1;
            end
        end
        // access error pulse for refused peripheral access
        state_next.perr_pulse = perr;
        // either master filter error raises the interrupt
        state_next.dma_irq = dma_mf | dte_mf;
        // sticky status; a new event beats a same-cycle clear
        state_next.stat = (state_reg.stat & ~st_clr) | st_set;
        // core reports state changes; no extension pins non-secure
        if (CPU_STATE_UPD)
        begin
            state_next.cur_ns = CPU_STATE_NS | ~SEC_EXT;
        end
        if (REG_WR && reg_sec)
        begin
            unique case (REG_ADDR)
                SAF_OFS_CTRL: state_next.ctrl = REG_WDATA[2:0];
                SAF_OFS_PERIPH_ATTR: state_next.psar = REG_WDATA;
                SAF_OFS_FINE_ATTR: state_next.fine = REG_WDATA;
                SAF_OFS_DMA_CH_ATTR: state_next.dmach = REG_WDATA[DMA_CHANNELS-1:0];
                // attributes of the bus master protection unit
                SAF_OFS_BMPU_ATTR: state_next.bmpu_attr = REG_WDATA[3:0];
                default:
                begin
                end
            endcase
        end
        if (REG_WR && REG_ADDR == SAF_OFS_BMPU_DENY)
        begin
            state_next.bmpu_deny = (state_reg.bmpu_deny & ~deny_mask) | (REG_WDATA[3:0] & deny_mask);
        end
        // region table loads only from the programming path in development state
        // protection applies to any region, secure or not
        // limitation: erase and write locks live in the flash sequencer;
        // this table only decides who may reach each block at all
        if (PROG_WE && LC_SSD)
        begin
            state_next.rbase[PROG_IDX] = PROG_BASE;
            state_next.rlimit[PROG_IDX] = PROG_LIMIT;
            state_next.rattr[PROG_IDX] = PROG_ATTR;
        end
        // read data stands only in the cycle after the strobe
        state_next.rdata = REG_RD ? rd_val : 32'h0000_0000;
    end

    // ------
    // registers
    // ------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= '0;
            state_reg.ctrl <= SAF_CTRL_RST;
            state_reg.psar <= SAF_PERIPH_ATTR_RST;
            state_reg.fine <= SAF_FINE_ATTR_RST;
            state_reg.bmpu_attr <= SAF_BMPU_RST;
            state_reg.bmpu_deny <= SAF_BMPU_RST;
            state_reg.rbase <= {SAF_REGIONS{SAF_RBASE_RST}};
            state_reg.rlimit <= {SAF_REGIONS{SAF_RLIMIT_RST}};
            state_reg.rattr <= {SAF_REGIONS{SAF_ATTR_S}};
            // come out of reset secure when the extension exists
            state_reg.cur_ns <= !SEC_EXT;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // registered outputs
    assign REG_RDATA = state_reg.rdata;
    assign PE_ERROR_FLAG = state_reg.stat[SAF_ST_PE_ERR];
    assign SECURE_FAULT_RESET = state_reg.fault_rst;
    assign SECURE_FAULT_NMI = state_reg.fault_nmi;
    assign PERIPH_ACCESS_ERR = state_reg.perr_pulse;
    assign DMA_TRANSFER_ERROR_IRQ = state_reg.dma_irq;
endmodule
`default_nettype wire

//--- testbench/saf_filter_assertions.sv
// concurrent checks on the security attribution filter ports
`timescale 1ns/1ps
`default_nettype none
module saf_filter_assertions
    import saf_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_NS,
    input wire logic [31:0] REG_RDATA,
    input wire logic CPU_STATE_UPD,
    input wire logic CPU_STATE_NS,
    input wire logic CPU_REQ,
    input wire logic CPU_GO,
    input wire logic CPU_ERR,
    input wire logic DMA_REQ,
    input wire logic DMA_GO,
    input wire logic DTE_REQ,
    input wire logic DTE_GO,
    input wire logic PE_ENTRY_REQ,
    input wire logic PE_ENTRY_NS,
    input wire logic PE_ENTRY_GO,
    input wire logic PE_ERROR_FLAG,
    input wire logic SECURE_FAULT_RESET,
    input wire logic SECURE_FAULT_NMI,
    input wire logic PERIPH_ACCESS_ERR,
    input wire logic DMA_TRANSFER_ERROR_IRQ
);
    // ------
    // core state mirror
    // ------
    // limitation: assumes the extension is present, so reset means secure
    logic ns_reg;
    always_ff @(posedge CLK)
    begin
        if (RST)
            ns_reg <= 1'h0;
        else if (CPU_STATE_UPD)
            ns_reg <= CPU_STATE_NS;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ------
    // checks
    // ------
    a_secure_cpu_go: assert property (CPU_REQ && !ns_reg |-> CPU_GO && !CPU_ERR)
        else $error("secure cpu access refused");
    a_err_no_go: assert property (CPU_ERR |-> !CPU_GO)
        else $error("erroring access still granted");
    a_fault_cause: assert property (SECURE_FAULT_RESET || SECURE_FAULT_NMI |-> $past(CPU_REQ && !CPU_GO && ns_reg))
        else $error("fault without a refused non-secure access");
    a_fault_kind: assert property (!(SECURE_FAULT_RESET && SECURE_FAULT_NMI))
        else $error("fault signalled both ways");
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data outside its cycle");
    a_ns_ctrl_blind: assert property ($past(REG_RD && REG_NS && REG_ADDR == SAF_OFS_CTRL) |-> REG_RDATA == 32'h0)
        else $error("non-secure read sees control");
    a_mf_irq_cause: assert property (DMA_TRANSFER_ERROR_IRQ |-> $past(DMA_REQ && !DMA_GO || DTE_REQ && !DTE_GO))
        else $error("dma error without refused master");
    a_periph_err_cause: assert property (PERIPH_ACCESS_ERR |-> $past(CPU_ERR || DMA_REQ && !DMA_GO || DTE_REQ && !DTE_GO))
        else $error("peripheral error without cause");
    a_pe_err_cause: assert property ($rose(PE_ERROR_FLAG) |-> $past(PE_ENTRY_REQ && !PE_ENTRY_GO))
        else $error("entry error without refused entry");
    a_pe_flag_hold: assert property ($fell(PE_ERROR_FLAG) |-> $past(REG_WR && REG_ADDR == SAF_OFS_STATUS && REG_WDATA[0]))
        else $error("entry error flag lost");
    a_pe_secure_go: assert property (PE_ENTRY_REQ && !PE_ENTRY_NS |-> PE_ENTRY_GO)
        else $error("secure entry refused");
    a_pe_refuse_clean: assert property (PE_ENTRY_REQ && !PE_ENTRY_GO && !CPU_REQ |=> !SECURE_FAULT_RESET && !SECURE_FAULT_NMI)
        else $error("refused entry raised a fault");
endmodule
bind saf_filter saf_filter_assertions saf_filter_assertions_inst (.CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_NS, .REG_RDATA, .CPU_STATE_UPD, .CPU_STATE_NS, .CPU_REQ, .CPU_GO, .CPU_ERR, .DMA_REQ, .DMA_GO, .DTE_REQ,
    .DTE_GO, .PE_ENTRY_REQ, .PE_ENTRY_NS, .PE_ENTRY_GO, .PE_ERROR_FLAG, .SECURE_FAULT_RESET, .SECURE_FAULT_NMI,
    .PERIPH_ACCESS_ERR, .DMA_TRANSFER_ERROR_IRQ);
`default_nettype wire

//--- testbench/saf_dma_master_model.sv
// general dma master stand-in issuing one-cycle requests
`timescale 1ns/1ps
`default_nettype none
module saf_dma_master_model
    import saf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [2:0] ch,
    input wire logic [31:0] addr,
    output logic req,
    output logic [2:0] req_ch,
    output logic [31:0] req_addr
);
    // idle lines toggle so a stale address can never pass for a live one
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req <= 1'h0;
            req_ch <= 3'h0;
            req_addr <= 32'h0;
        end
        else if (start)
        begin
            req <= 1'h1;
            req_ch <= ch;
            req_addr <= addr;
        end
        else
        begin
            req <= 1'h0;
            req_ch <= ~req_ch;
            req_addr <= ~req_addr;
        end
    end
endmodule
`default_nettype wire

//--- testbench/saf_filter_tb.sv
// self-checking bench for the security attribution filter
`timescale 1ns/1ps
`default_nettype none
module saf_filter_tb
    import saf_pkg::*;
;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, rns = 1'h0, secure_dev_lifecycle_state = 1'h0, pwe = 1'h0, su = 1'h0, sns = 1'h0;
    logic creq = 1'h0, cw = 1'h0, treq = 1'h0, tns = 1'h0, ereq = 1'h0, dst = 1'h0;
    logic pereq = 1'h0, pens = 1'h0, sreq = 1'h0, srns = 1'h0;
    logic [7:0] ra = 8'h0;
    logic [31:0] wd = 32'h0, xa = 32'h0, pb = 32'h0, pl = 32'h0, da = 32'h0, rdat, ma;
    logic [2:0] pidx = 3'h0, dch = 3'h0, mch;
    logic [1:0] pat = 2'h0;
    logic mreq, cgo, cerr, dgo, dbns, tgo, ego, pego, peflag, sgo, fr, fn, perr, irq;
    int failures = 0, num_checks = 0, cycles = 0;
    saf_filter saf_filter_inst (.CLK(clk), .RST(rst), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
        .REG_NS(rns), .REG_RDATA(rdat), .LC_SSD(secure_dev_lifecycle_state), .PROG_WE(pwe), .PROG_IDX(pidx), .PROG_BASE(pb),
        .PROG_LIMIT(pl), .PROG_ATTR(pat), .CPU_STATE_UPD(su), .CPU_STATE_NS(sns), .CPU_REQ(creq), .CPU_ADDR(xa),
        .CPU_WRITE(cw), .CPU_GO(cgo), .CPU_ERR(cerr), .DMA_REQ(mreq), .DMA_CH(mch), .DMA_ADDR(ma), .DMA_WRITE(1'h0),
        .DMA_GO(dgo), .DMA_BUS_NS(dbns), .DTE_REQ(treq), .DTE_NS(tns), .DTE_ADDR(xa), .DTE_WRITE(1'h0),
        .DTE_GO(tgo), .ETH_REQ(ereq), .ETH_ADDR(xa), .ETH_WRITE(1'h0), .ETH_GO(ego), .PE_ENTRY_REQ(pereq),
        .PE_ENTRY_NS(pens), .PE_ENTRY_GO(pego), .PE_ERROR_FLAG(peflag), .DMA_START_REQ(sreq), .DMA_START_NS(srns),
        .DMA_START_GO(sgo), .SECURE_FAULT_RESET(fr), .SECURE_FAULT_NMI(fn), .PERIPH_ACCESS_ERR(perr),
        .DMA_TRANSFER_ERROR_IRQ(irq));
    saf_dma_master_model saf_dma_master_model_inst (.clk(clk), .rst(rst), .start(dst), .ch(dch), .addr(da),
        .req(mreq), .req_ch(mch), .req_addr(ma));
    // ------
    // clock, watchdog and shared tasks
    // ------
    initial forever #2 clk = ~clk;
    // run needs about 150 cycles, so 5000 only trips on a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic ns);
        @(posedge clk);
        ra <= a;
        wd <= d;
        rns <= ns;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic ns, input logic [31:0] exp);
        @(posedge clk);
        ra <= a;
        rns <= ns;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(rdat, exp);
    endtask
    // m selects the master: 0 cpu, 1 transfer engine (w is its state), 2 ethernet
    task automatic acc(input int m, input logic [31:0] a, input logic w, input logic go, input logic er);
        @(posedge clk);
        creq <= (m == 0);
        treq <= (m == 1);
        ereq <= (m == 2);
        xa <= a;
        cw <= w;
        tns <= w;
        #1;
        chk((m == 0) ? cgo : ((m == 1) ? tgo : ego), go);
        chk(cerr, er);
        @(posedge clk);
        creq <= 1'h0;
        treq <= 1'h0;
        ereq <= 1'h0;
        xa <= ~a;
        #1;
    endtask
    task automatic dma(input logic [2:0] c, input logic [31:0] a, input logic go, input logic bns);
        @(posedge clk);
        dst <= 1'h1;
        dch <= c;
        da <= a;
        @(posedge clk);
        dst <= 1'h0;
        #1;
        chk(dgo, go);
        chk(dbns, bns);
        @(posedge clk);
        #1;
    endtask
    task automatic pe(input logic ns, input logic pgo, input logic go);
        @(posedge clk);
        pereq <= 1'h1;
        sreq <= 1'h1;
        pens <= ns;
        srns <= ns;
        #1;
        chk(pego, pgo);
        chk(sgo, go);
        @(posedge clk);
        pereq <= 1'h0;
        sreq <= 1'h0;
        #1;
    endtask
    task automatic prg(input logic [2:0] i, input logic [31:0] b, input logic [31:0] l, input logic [1:0] at);
        @(posedge clk);
        pwe <= 1'h1;
        pidx <= i;
        pb <= b;
        pl <= l;
        pat <= at;
        @(posedge clk);
        pwe <= 1'h0;
    endtask
    task automatic cst(input logic ns);
        @(posedge clk);
        su <= 1'h1;
        sns <= ns;
        @(posedge clk);
        su <= 1'h0;
    endtask
    // ------
    // test sequence
    // ------
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rreg(SAF_OFS_CTRL, 1'h0, 32'h0);
        rreg(SAF_OFS_STATUS, 1'h0, 32'h0);
        rreg(SAF_OFS_DMA_CH_ATTR, 1'h0, 32'h0);
        rreg(8'h40, 1'h0, 32'h0);
        $display("test 1 done");
        acc(0, 32'h100, 1'h0, 1'h1, 1'h0);
        cst(1'h1);
        acc(0, 32'h100, 1'h0, 1'h0, 1'h0);
        chk({fr, fn}, 32'h2);
        rreg(SAF_OFS_STATUS, 1'h0, 32'h108);
        $display("test 2 done");
        wreg(SAF_OFS_CTRL, 32'h7, 1'h1);
        rreg(SAF_OFS_CTRL, 1'h0, 32'h0);
        wreg(SAF_OFS_CTRL, 32'h2, 1'h0);
        rreg(SAF_OFS_CTRL, 1'h1, 32'h0);
        acc(0, 32'h2000_0010, 1'h1, 1'h0, 1'h0);
        chk({fr, fn}, 32'h1);
        $display("test 3 done");
        prg(3'h0, 32'h2000_0000, 32'h2000_0FFF, SAF_ATTR_NS);
        acc(0, 32'h2000_0010, 1'h1, 1'h0, 1'h0);
        @(posedge clk) secure_dev_lifecycle_state <= 1'h1;
        prg(3'h0, 32'h2000_0000, 32'h2000_0FFF, SAF_ATTR_NS);
        prg(3'h1, 32'h1000, 32'h1FFF, SAF_ATTR_NSC);
        acc(0, 32'h2000_0010, 1'h1, 1'h1, 1'h0);
        acc(0, 32'h1010, 1'h0, 1'h1, 1'h0);
        acc(0, 32'h1010, 1'h1, 1'h0, 1'h0);
        wreg(SAF_OFS_STATUS, 32'h3F, 1'h0);
        rreg(SAF_OFS_STATUS, 1'h0, 32'h300);
        $display("test 4 done");
        pe(1'h1, 1'h0, 1'h0);
        chk({peflag, fr, fn}, 32'h4);
        pe(1'h0, 1'h1, 1'h1);
        wreg(SAF_OFS_CTRL, 32'h7, 1'h0);
        pe(1'h1, 1'h1, 1'h1);
        wreg(SAF_OFS_CTRL, 32'h0, 1'h1);
        pe(1'h1, 1'h1, 1'h1);
        $display("test 5 done");
        dma(3'h3, 32'h100, 1'h1, 1'h0);
        wreg(SAF_OFS_DMA_CH_ATTR, 32'h8, 1'h1);
        dma(3'h3, 32'h100, 1'h1, 1'h0);
        wreg(SAF_OFS_DMA_CH_ATTR, 32'h8, 1'h0);
        dma(3'h3, 32'h100, 1'h0, 1'h1);
        chk(irq, 32'h1);
        dma(3'h2, 32'h100, 1'h1, 1'h0);
        acc(1, 32'h100, 1'h1, 1'h0, 1'h0);
        chk(irq, 32'h1);
        acc(1, 32'h100, 1'h0, 1'h1, 1'h0);
        rreg(SAF_OFS_STATUS, 1'h0, 32'h307);
        wreg(SAF_OFS_STATUS, 32'h1, 1'h0);
        rreg(SAF_OFS_STATUS, 1'h0, 32'h306);
        wreg(SAF_OFS_BMPU_DENY, 32'h1, 1'h1);
        dma(3'h2, 32'h100, 1'h1, 1'h0);
        wreg(SAF_OFS_BMPU_DENY, 32'h1, 1'h0);
        dma(3'h2, 32'h100, 1'h0, 1'h0);
        chk(irq, 32'h0);
        wreg(SAF_OFS_BMPU_DENY, 32'h0, 1'h0);
        $display("test 6 done");
        acc(0, 32'h4000_0000, 1'h0, 1'h0, 1'h1);
        chk(perr, 32'h1);
        acc(0, 32'h4001_C000, 1'h1, 1'h1, 1'h0);
        wreg(SAF_OFS_PERIPH_ATTR, 32'h4, 1'h1);
        acc(0, 32'h4000_2000, 1'h1, 1'h0, 1'h1);
        wreg(SAF_OFS_PERIPH_ATTR, 32'h4, 1'h0);
        acc(0, 32'h4000_2000, 1'h1, 1'h1, 1'h0);
        acc(0, 32'h4000_0000, 1'h0, 1'h0, 1'h1);
        wreg(SAF_OFS_FINE_ATTR, 32'h5, 1'h1);
        rreg(SAF_OFS_FINE_ATTR, 1'h0, 32'h0);
        wreg(SAF_OFS_FINE_ATTR, 32'h5, 1'h0);
        rreg(SAF_OFS_FINE_ATTR, 1'h0, 32'h5);
        $display("test 7 done");
        acc(2, 32'h2000_2000, 1'h0, 1'h0, 1'h0);
        acc(2, 32'h2000_0010, 1'h0, 1'h1, 1'h0);
        cst(1'h0);
        acc(0, 32'h2000_2000, 1'h1, 1'h1, 1'h0);
        acc(0, 32'h4000_0000, 1'h0, 1'h1, 1'h0);
        $display("test 8 done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
